// ===== rtl/otpsec_pkg.sv
// constants and types of the otp security and jtag id block
// Summary of operation
// - otp has four lockable 512x32 sectors
// - security word loads from otp before run
// - remaining otp rows copied to sram first
// - program via 16b address, 32b data, 16b control
// - bit 0 blocks jtag tile access
// - bit 1 refuses link requests from tiles
// - bit 5 boots from otp address zero
// - bit 5 clear boots from internal flash
// - bit 7 enables redundant otp rows
// - bits 8-11 lock sectors 0-3
// - bit 12 rejects every programming attempt
// - bit 13 denies jtag otp access
// - general purpose bits readable by software
// - usercode id from bits 22-31
// - chain holds boundary tap and chip tap
// - five tms high cycles reset jtag
// - idcode returns version, part, maker fields
// - usercode returns id, unused, revision
package otpsec_pkg;
  // ==========================================
  // security word
  localparam int SEC_DIS_JTAG = 0;
  localparam int SEC_DIS_LINK = 1;
  localparam int SEC_BOOT_OTP = 5;
  localparam int SEC_REDUND = 7;
  localparam int SEC_LOCK0 = 8;
  localparam int SEC_MLOCK = 12;
  localparam int SEC_DIS_JOTP = 13;
  localparam int SEC_UID_LSB = 22;
  localparam logic [31:0] SEC_DEF_MASK = 32'hffff_bfa3;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  // ==========================================
  // otp array
  localparam int OTP_ROWS_PER_SECTOR = 512;
  localparam int OTP_SECTORS = 4;
  localparam logic [15:0] OTP_ROWS = 16'(OTP_ROWS_PER_SECTOR * OTP_SECTORS);
  localparam logic [15:0] OTP_SEC_ROW = 16'h0800;
  localparam logic [23:0] RID_PGM_ADDR = 24'h10_0200;
  localparam logic [23:0] RID_PGM_DATA = 24'h20_0100;
  localparam logic [23:0] RID_PGM_CTRL = 24'h10_0300;
  // ==========================================
  // register map
  localparam logic [7:0] REG_SEC = 8'h00;
  localparam logic [7:0] REG_PADDR = 8'h04;
  localparam logic [7:0] REG_PDATA = 8'h08;
  localparam logic [7:0] REG_PCTRL = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int PCTRL_START = 0;
  localparam int ST_LOADED = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REJ = 2;
  localparam int ST_LDENY = 3;
  // ==========================================
  // jtag
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h2;
  localparam logic [3:0] IR_ACCESS = 4'h3;
  localparam logic [3:0] IR_OTP = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [2:0] TMS_RESET_CNT = 3'd5;
  typedef enum logic [4:0] {
    LD_SEC_RQ = 5'h01, LD_SEC_CAP = 5'h02, LD_COPY = 5'h04, LD_DRAIN = 5'h08, LD_RUN = 5'h10
  } otpsec_ld_t;
  typedef enum logic [15:0] {
    T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDS = 16'h0004, T_CDR = 16'h0008,
    T_SDR = 16'h0010, T_E1D = 16'h0020, T_PDR = 16'h0040, T_E2D = 16'h0080,
    T_UDR = 16'h0100, T_SIS = 16'h0200, T_CIR = 16'h0400, T_SIR = 16'h0800,
    T_E1I = 16'h1000, T_PIR = 16'h2000, T_E2I = 16'h4000, T_UIR = 16'h8000
  } otpsec_tap_t;
endpackage : otpsec_pkg

// ===== rtl/otpsec_if.sv
// link between the top and one jtag tap
`timescale 1ns/1ps
interface otpsec_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic allow_acc;
  logic allow_otp;
  logic [9:0] user_id;
  logic tdo;
  logic sel_acc;
  logic sel_otp;
  modport top (output tck_rise, tck_fall, tms, tdi, allow_acc, allow_otp, user_id, input tdo, sel_acc, sel_otp);
  modport tap (input tck_rise, tck_fall, tms, tdi, allow_acc, allow_otp, user_id, output tdo, sel_acc, sel_otp);
endinterface : otpsec_if

// ===== rtl/otpsec_tap.sv
// one jtag tap controller with idcode, usercode and access paths
`timescale 1ns/1ps
module otpsec_tap import otpsec_pkg::*; #(
  parameter logic [3:0] VERSION = 4'h0,   // arbitrary value
  parameter logic [15:0] PART = 16'h0001, // arbitrary value
  parameter logic [10:0] MAKER = 11'h001, // arbitrary value
  parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
  input wire logic CLK,
  input wire logic SRST,
  otpsec_if.tap jt
);
  otpsec_tap_t st_q, st_d;
  logic [2:0] hi_q;
  logic [3:0] ir_q, irs_q;
  logic [31:0] dr_q;
  logic tdo_q;
  logic full_dr;
  // ==========================================
  // state walk
  always_comb begin
    case (st_q)
      T_TLR: st_d = jt.tms ? T_TLR : T_RTI;
      T_RTI: st_d = jt.tms ? T_SDS : T_RTI;
      T_SDS: st_d = jt.tms ? T_SIS : T_CDR;
      T_CDR: st_d = jt.tms ? T_E1D : T_SDR;
      T_SDR: st_d = jt.tms ? T_E1D : T_SDR;
      T_E1D: st_d = jt.tms ? T_UDR : T_PDR;
      T_PDR: st_d = jt.tms ? T_E2D : T_PDR;
      T_E2D: st_d = jt.tms ? T_UDR : T_SDR;
      T_UDR: st_d = jt.tms ? T_SDS : T_RTI;
      T_SIS: st_d = jt.tms ? T_TLR : T_CIR;
      T_CIR: st_d = jt.tms ? T_E1I : T_SIR;
      T_SIR: st_d = jt.tms ? T_E1I : T_SIR;
      T_E1I: st_d = jt.tms ? T_UIR : T_PIR;
      T_PIR: st_d = jt.tms ? T_E2I : T_PIR;
      T_E2I: st_d = jt.tms ? T_UIR : T_SIR;
      T_UIR: st_d = jt.tms ? T_SDS : T_RTI;
      default: st_d = T_TLR;
    endcase
  end
  // five high tms cycles force reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= T_TLR;
      hi_q <= 3'd0;
    end else if (jt.tck_rise) begin
      hi_q <= jt.tms ? ((hi_q == TMS_RESET_CNT) ? hi_q : hi_q + 3'd1) : 3'd0;
      st_q <= (jt.tms && hi_q >= TMS_RESET_CNT - 3'd1) ? T_TLR : st_d;
    end
  end
  // ==========================================
  // instruction register; blocked paths fall back to bypass
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ir_q <= IR_IDCODE;
      irs_q <= IR_CAPTURE;
    end else if (jt.tck_rise) begin
      case (st_q)
        T_TLR: ir_q <= IR_IDCODE;
        T_CIR: irs_q <= IR_CAPTURE;
        T_SIR: irs_q <= {jt.tdi, irs_q[3:1]};
        T_UIR: ir_q <= irs_q;
        default: ir_q <= ir_q;
      endcase
    end
  end
  assign jt.sel_acc = (ir_q == IR_ACCESS) && jt.allow_acc;
  assign jt.sel_otp = (ir_q == IR_OTP) && jt.allow_otp;
  assign full_dr = (ir_q == IR_IDCODE) || (ir_q == IR_USERCODE) || jt.sel_acc || jt.sel_otp;
  // ==========================================
  // data register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dr_q <= 32'h0000_0000;
    end else if (jt.tck_rise) begin
      case (st_q)
        T_CDR: begin
          if (ir_q == IR_IDCODE) dr_q <= {VERSION, PART, MAKER, 1'b1};
          else if (ir_q == IR_USERCODE) dr_q <= {jt.user_id, 6'h00, REVISION};
          else dr_q <= 32'h0000_0000;
        end
        T_SDR: dr_q <= full_dr ? {jt.tdi, dr_q[31:1]} : {31'h0000_0000, jt.tdi};
        default: dr_q <= dr_q;
      endcase
    end
  end
  // tdo changes on the falling test clock edge
  always_ff @(posedge CLK) begin
    if (SRST) tdo_q <= 1'b0;
    else if (jt.tck_fall && st_q == T_SDR) tdo_q <= dr_q[0];
    else if (jt.tck_fall && st_q == T_SIR) tdo_q <= irs_q[0];
  end
  assign jt.tdo = tdo_q;
endmodule : otpsec_tap

// ===== rtl/otpsec_top.sv
// otp security configuration, boot loader, program gate and jtag chain
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module otpsec_top import otpsec_pkg::*; (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic OTP_RD_EN,
  output logic [15:0] OTP_RD_ADDR,
  input wire logic [31:0] OTP_RD_DATA,
  output logic OTP_PGM_EN,
  output logic [15:0] OTP_PGM_ADDR,
  output logic [31:0] OTP_PGM_DATA,
  output logic [15:0] OTP_PGM_CTRL,
  output logic OTP_REDUND_EN,
  output logic SRAM_WE,
  output logic [10:0] SRAM_ADDR,
  output logic [31:0] SRAM_WDATA,
  output logic CORE_RUN,
  output logic BOOT_FROM_OTP,
  output logic BOOT_FROM_FLASH,
  input wire logic LINK_REQ,
  output logic LINK_GRANT,
  output logic LINK_DENY,
  input wire logic JTAG_TCK,
  input wire logic JTAG_TMS,
  input wire logic JTAG_TDI,
  output logic JTAG_TDO,
  output logic JTAG_TILE_SEL,
  output logic JTAG_OTP_SEL,
  output logic BSCAN_EXTEST
);
  otpsec_ld_t ld_q;
  logic [31:0] sec_q;
  logic [15:0] cnt_q;
  logic copy_q;
  logic rd_en_q;
  logic [15:0] rd_addr_q;
  logic sram_we_q;
  logic [10:0] sram_addr_q;
  logic [31:0] sram_wdata_q;
  logic run_q, boot_otp_q, redund_q;
  logic wr_q, rd_q, rd_ok_q;
  logic [7:0] aadr_q;
  logic [31:0] hrdata_q, rd_mux;
  logic wr_en;
  logic [15:0] paddr_q, pctrl_q;
  logic [31:0] pdata_q;
  logic [3:0] stat_q;
  logic pgm_start, pgm_locked;
  logic pgm_en_q;
  logic [15:0] pgm_addr_q, pgm_ctrl_q;
  logic [31:0] pgm_data_q;
  logic [2:0] s1_q, s2_q, s3_q, flt_q;
  logic tck_prev_q;
  logic [2:0] agree;

  // ==========================================
  // power-up loader
  // four sectors of 512 rows each
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ld_q <= LD_SEC_RQ;
      cnt_q <= 16'h0000;
      rd_en_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      copy_q <= 1'b0;
    end else begin
      case (ld_q)
        LD_SEC_RQ: begin
          rd_en_q <= 1'b1;
          rd_addr_q <= OTP_SEC_ROW;
          ld_q <= LD_SEC_CAP;
        end
        LD_SEC_CAP: begin
          rd_en_q <= 1'b0;
          ld_q <= LD_COPY;
        end
        LD_COPY: begin
          // stream every array row to sram
          rd_en_q <= 1'b1;
          copy_q <= 1'b1;
          rd_addr_q <= cnt_q;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == OTP_ROWS - 16'h0001) ld_q <= LD_DRAIN;
        end
        LD_DRAIN: begin
          rd_en_q <= 1'b0;
          copy_q <= 1'b0;
          ld_q <= LD_RUN;
        end
        LD_RUN: ld_q <= LD_RUN;
        default: ld_q <= LD_SEC_RQ;
      endcase
    end
  end
  // read data is taken in the same cycle that OTP_RD_EN requests it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sec_q <= SEC_RESET;
    end else if (ld_q == LD_SEC_CAP) begin
      sec_q <= OTP_RD_DATA & SEC_DEF_MASK;
    end
  end
  // no path rewrites sec_q until reset

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sram_we_q <= 1'b0;
      sram_addr_q <= 11'h000;
      sram_wdata_q <= 32'h0000_0000;
    end else begin
      sram_we_q <= rd_en_q && copy_q;
      sram_addr_q <= rd_addr_q[10:0];
      sram_wdata_q <= OTP_RD_DATA;
    end
  end
  assign OTP_RD_EN = rd_en_q;
  assign OTP_RD_ADDR = rd_addr_q;
  assign SRAM_WE = sram_we_q;
  assign SRAM_ADDR = sram_addr_q;
  assign SRAM_WDATA = sram_wdata_q;

  // ==========================================
  // boot and array options
  always_ff @(posedge CLK) begin
    if (SRST) begin
      run_q <= 1'b0;
      boot_otp_q <= 1'b0;
      redund_q <= 1'b0;
    end else if (ld_q == LD_DRAIN) begin
      run_q <= 1'b1;
      // secure boot from otp row zero
      boot_otp_q <= sec_q[SEC_BOOT_OTP];
      redund_q <= sec_q[SEC_REDUND];
    end
  end
  assign CORE_RUN = run_q;
  assign BOOT_FROM_OTP = boot_otp_q;
  assign BOOT_FROM_FLASH = run_q && !boot_otp_q;
  assign OTP_REDUND_EN = redund_q;

  // ==========================================
  // link gate; refused until CORE_RUN rises
  // refuse other tiles when bit set
  assign LINK_GRANT = LINK_REQ && run_q && !sec_q[SEC_DIS_LINK];
  assign LINK_DENY = LINK_REQ && !(run_q && !sec_q[SEC_DIS_LINK]);

  // ==========================================
  // ahb-lite slave; reads take one wait state
  assign HREADYOUT = !rd_q || rd_ok_q;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;
  assign wr_en = wr_q && HREADY;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_ok_q <= 1'b0;
      aadr_q <= 8'h00;
    end else begin
      rd_ok_q <= rd_q && !rd_ok_q;
      if (HSEL && HTRANS[1] && HREADY) begin
        wr_q <= HWRITE && (HSIZE == 3'b010);
        rd_q <= !HWRITE;
        aadr_q <= HADDR[7:0];
      end else if (HREADY) begin
        wr_q <= 1'b0;
        rd_q <= 1'b0;
      end
    end
  end
  always_comb begin
    case (aadr_q)
      REG_SEC: rd_mux = sec_q;
      REG_PADDR: rd_mux = {16'h0000, paddr_q};
      REG_PDATA: rd_mux = pdata_q;
      REG_PCTRL: rd_mux = {16'h0000, pctrl_q};
      REG_STAT: rd_mux = {28'h000_0000, stat_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SRST) hrdata_q <= 32'h0000_0000;
    else if (rd_q && !rd_ok_q) hrdata_q <= rd_mux;
  end

  // ==========================================
  // program ports; start bit is a strobe and reads zero
  // address, data and control ports
  always_ff @(posedge CLK) begin
    if (SRST) begin
      paddr_q <= 16'h0000;
      pdata_q <= 32'h0000_0000;
      pctrl_q <= 16'h0000;
    end else if (wr_en) begin
      if (aadr_q == REG_PADDR) paddr_q <= HWDATA[15:0];
      if (aadr_q == REG_PDATA) pdata_q <= HWDATA;
      if (aadr_q == REG_PCTRL) pctrl_q <= HWDATA[15:0] & ~16'h0001;
    end
  end
  assign pgm_start = wr_en && (aadr_q == REG_PCTRL) && HWDATA[PCTRL_START];
  always_comb begin
    if (!run_q || sec_q[SEC_MLOCK]) pgm_locked = 1'b1;
    else if (paddr_q == OTP_SEC_ROW) pgm_locked = 1'b0;
    else if (paddr_q < OTP_ROWS) pgm_locked = sec_q[SEC_LOCK0 + int'(paddr_q[10:9])];
    else pgm_locked = 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pgm_en_q <= 1'b0;
      pgm_addr_q <= 16'h0000;
      pgm_data_q <= 32'h0000_0000;
      pgm_ctrl_q <= 16'h0000;
    end else begin
      pgm_en_q <= pgm_start && !pgm_locked;
      if (pgm_start && !pgm_locked) begin
        pgm_addr_q <= paddr_q;
        pgm_data_q <= pdata_q;
        pgm_ctrl_q <= HWDATA[15:0];
      end
    end
  end
  assign OTP_PGM_EN = pgm_en_q;
  assign OTP_PGM_ADDR = pgm_addr_q;
  assign OTP_PGM_DATA = pgm_data_q;
  assign OTP_PGM_CTRL = pgm_ctrl_q;
  // status: done, reject and link-deny bits write one clears, a new event wins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat_q <= 4'h0;
    end else begin
      stat_q[ST_LOADED] <= run_q;
      stat_q[ST_DONE] <= (pgm_start && !pgm_locked) ||
                         (stat_q[ST_DONE] && !(wr_en && aadr_q == REG_STAT && HWDATA[ST_DONE]));
      stat_q[ST_REJ] <= (pgm_start && pgm_locked) ||
                        (stat_q[ST_REJ] && !(wr_en && aadr_q == REG_STAT && HWDATA[ST_REJ]));
      stat_q[ST_LDENY] <= LINK_DENY ||
                          (stat_q[ST_LDENY] && !(wr_en && aadr_q == REG_STAT && HWDATA[ST_LDENY]));
    end
  end

  // ==========================================
  // jtag pin filter: three flops, act when the last two agree
  assign agree = ~(s2_q ^ s3_q);
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      flt_q <= 3'h0;
      tck_prev_q <= 1'b0;
    end else begin
      s1_q <= {JTAG_TDI, JTAG_TMS, JTAG_TCK};
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= (agree & s3_q) | (~agree & flt_q);
      tck_prev_q <= flt_q[0];
    end
  end

  // ==========================================
  // jtag chain: pin -> boundary tap -> chip tap -> pin
  // two taps present after reset
  otpsec_if bs_if();
  otpsec_if ch_if();
  assign bs_if.tck_rise = flt_q[0] && !tck_prev_q;
  assign bs_if.tck_fall = !flt_q[0] && tck_prev_q;
  assign bs_if.tms = flt_q[1];
  assign bs_if.tdi = flt_q[2];
  assign bs_if.allow_acc = 1'b1;
  assign bs_if.allow_otp = 1'b0;
  assign bs_if.user_id = sec_q[31:SEC_UID_LSB];
  assign ch_if.tck_rise = bs_if.tck_rise;
  assign ch_if.tck_fall = bs_if.tck_fall;
  assign ch_if.tms = flt_q[1];
  assign ch_if.tdi = bs_if.tdo;
  // tile paths shut by bit 0
  assign ch_if.allow_acc = !sec_q[SEC_DIS_JTAG];
  // otp path shut by bit 13
  assign ch_if.allow_otp = !sec_q[SEC_DIS_JOTP];
  // user id from top ten bits
  assign ch_if.user_id = sec_q[31:SEC_UID_LSB];
  otpsec_tap #(.PART(16'h0002)) u_bscan (.CLK(CLK), .SRST(SRST), .jt(bs_if));
  otpsec_tap #(.PART(16'h0003)) u_chip (.CLK(CLK), .SRST(SRST), .jt(ch_if));
  assign JTAG_TDO = ch_if.tdo;
  assign JTAG_TILE_SEL = ch_if.sel_acc;
  assign JTAG_OTP_SEL = ch_if.sel_otp;
  assign BSCAN_EXTEST = bs_if.sel_acc;

  // ==========================================
  // checks
  AST_SEC_STICKY: assert property (@(posedge CLK) disable iff (SRST)
    (ld_q == LD_RUN) |=> $stable(sec_q)) else $error("security word changed after load");
  AST_DEF_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    (sec_q & ~SEC_DEF_MASK) == 32'h0000_0000) else $error("undefined security bit set");
  AST_SECTOR_LOCK: assert property (@(posedge CLK) disable iff (SRST)
    (pgm_start && run_q && paddr_q < OTP_ROWS && sec_q[SEC_LOCK0 + int'(paddr_q[10:9])])
    |=> !OTP_PGM_EN && stat_q[ST_REJ]) else $error("locked sector programmed");
  AST_MASTER_LOCK: assert property (@(posedge CLK) disable iff (SRST)
    sec_q[SEC_MLOCK] && $past(sec_q[SEC_MLOCK]) |-> !OTP_PGM_EN) else $error("program under master lock");
  AST_LINK_DENY: assert property (@(posedge CLK) disable iff (SRST)
    LINK_REQ && sec_q[SEC_DIS_LINK] |-> !LINK_GRANT && LINK_DENY) else $error("link granted when disabled");
  AST_JTAG_BLOCK: assert property (@(posedge CLK) disable iff (SRST)
    sec_q[SEC_DIS_JTAG] |-> !JTAG_TILE_SEL) else $error("jtag tile path open");
  AST_JOTP_BLOCK: assert property (@(posedge CLK) disable iff (SRST)
    sec_q[SEC_DIS_JOTP] |-> !JTAG_OTP_SEL) else $error("jtag otp path open");
  AST_BOOT_SRC: assert property (@(posedge CLK) disable iff (SRST)
    CORE_RUN |-> (BOOT_FROM_OTP == sec_q[SEC_BOOT_OTP]) && (BOOT_FROM_FLASH != BOOT_FROM_OTP))
    else $error("boot source wrong");
  AST_RUN_AFTER_COPY: assert property (@(posedge CLK) disable iff (SRST)
    $rose(CORE_RUN) |-> $past(ld_q == LD_DRAIN) && $past(sram_we_q, 2)) else $error("run before copy");
  AST_COPY_PAIR: assert property (@(posedge CLK) disable iff (SRST)
    SRAM_WE |-> $past(OTP_RD_EN) && SRAM_ADDR == $past(OTP_RD_ADDR[10:0])) else $error("sram write unpaired");
  AST_REDUND: assert property (@(posedge CLK) disable iff (SRST)
    CORE_RUN |-> OTP_REDUND_EN == sec_q[SEC_REDUND]) else $error("redundant rows mismatch");
  AST_USER_ID: assert property (@(posedge CLK) disable iff (SRST)
    ch_if.user_id == sec_q[31:22]) else $error("user id not from security word");
endmodule : otpsec_top

// ===== testbench/otpsec_otp_model.sv
// otp array model for the security block bench
`timescale 1ns/1ps
module otpsec_otp_model import otpsec_pkg::*; #(
  parameter logic [31:0] SEC_WORD = 32'ha955c1fe
) (
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic pgm_en,
  input wire logic [15:0] pgm_addr,
  input wire logic [31:0] pgm_data
);
  // ==========
  // array
  logic [31:0] mem_q [0:2048];
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem_q[i] = {16'hc3a5, 16'(i)};
    end
    mem_q[2048] = SEC_WORD;
  end
  // row valid in the cycle of the request
  // no read: junk, so a late sample shows up
  assign rd_data = (rd_en && rd_addr <= 16'h0800) ? mem_q[rd_addr[11:0]] : 32'h5a5a_a5a5;
  always @(posedge clk) begin
    if (pgm_en && pgm_addr <= 16'h0800) begin
      mem_q[pgm_addr[11:0]] <= mem_q[pgm_addr[11:0]] | pgm_data;
    end
  end
endmodule : otpsec_otp_model

// ===== testbench/tb_otp_security_jtag_id.sv
// self-checking bench for the otp security block
`timescale 1ns/1ps
module tb_otp_security_jtag_id;
  import otpsec_pkg::*;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic LINK_REQ = 1'b0;
  logic JTAG_TCK = 1'b0;
  logic JTAG_TMS = 1'b1;
  logic JTAG_TDI = 1'b0;
  logic [31:0] HRDATA, OTP_RD_DATA, OTP_PGM_DATA, SRAM_WDATA, rdv, row5;
  logic HREADYOUT, HRESP, OTP_RD_EN, OTP_PGM_EN, OTP_REDUND_EN, SRAM_WE, CORE_RUN;
  logic [15:0] OTP_RD_ADDR, OTP_PGM_ADDR, OTP_PGM_CTRL;
  logic [10:0] SRAM_ADDR;
  logic BOOT_FROM_OTP, BOOT_FROM_FLASH, LINK_GRANT, LINK_DENY;
  logic JTAG_TDO, JTAG_TILE_SEL, JTAG_OTP_SEL, BSCAN_EXTEST;
  logic [79:0] tdo;
  int failures = 0;
  int compares = 0;
  int n_we = 0;
  int n_pgm = 0;
  always #12.5 CLK = ~CLK;
  otpsec_top DUT (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OTP_RD_EN(OTP_RD_EN), .OTP_RD_ADDR(OTP_RD_ADDR),
    .OTP_RD_DATA(OTP_RD_DATA), .OTP_PGM_EN(OTP_PGM_EN), .OTP_PGM_ADDR(OTP_PGM_ADDR),
    .OTP_PGM_DATA(OTP_PGM_DATA), .OTP_PGM_CTRL(OTP_PGM_CTRL), .OTP_REDUND_EN(OTP_REDUND_EN),
    .SRAM_WE(SRAM_WE), .SRAM_ADDR(SRAM_ADDR), .SRAM_WDATA(SRAM_WDATA), .CORE_RUN(CORE_RUN),
    .BOOT_FROM_OTP(BOOT_FROM_OTP), .BOOT_FROM_FLASH(BOOT_FROM_FLASH), .LINK_REQ(LINK_REQ),
    .LINK_GRANT(LINK_GRANT), .LINK_DENY(LINK_DENY), .JTAG_TCK(JTAG_TCK), .JTAG_TMS(JTAG_TMS),
    .JTAG_TDI(JTAG_TDI), .JTAG_TDO(JTAG_TDO), .JTAG_TILE_SEL(JTAG_TILE_SEL),
    .JTAG_OTP_SEL(JTAG_OTP_SEL), .BSCAN_EXTEST(BSCAN_EXTEST));
  otpsec_otp_model otp (.clk(CLK), .rd_en(OTP_RD_EN), .rd_addr(OTP_RD_ADDR), .rd_data(OTP_RD_DATA),
    .pgm_en(OTP_PGM_EN), .pgm_addr(OTP_PGM_ADDR), .pgm_data(OTP_PGM_DATA));
  always @(posedge CLK) begin
    if (SRAM_WE === 1'b1) n_we <= n_we + 1;
    if (SRAM_WE === 1'b1 && SRAM_ADDR === 11'd5) row5 <= SRAM_WDATA;
    if (OTP_PGM_EN === 1'b1) n_pgm <= n_pgm + 1;
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rdv = HRDATA;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rdc
  task automatic pgm(input logic [15:0] a, input logic [31:0] d);
    ahb(1'b1, REG_PADDR, {16'h0, a});
    ahb(1'b1, REG_PDATA, d);
    ahb(1'b1, REG_PCTRL, 32'h1);
    repeat (2) @(posedge CLK);
  endtask : pgm
  // tck half period of 10 clocks, tdo taken before each rise
  task automatic jseq(input logic [79:0] tms, input logic [79:0] tdi, input int n);
    for (int i = 0; i < n; i++) begin
      JTAG_TMS <= tms[i];
      JTAG_TDI <= tdi[i];
      JTAG_TCK <= 1'b0;
      repeat (10) @(posedge CLK);
      tdo[i] = JTAG_TDO;
      JTAG_TCK <= 1'b1;
      repeat (10) @(posedge CLK);
    end
  endtask : jseq
  // chip ir shifts in first; boundary tap left in bypass
  task automatic jir(input logic [3:0] ir);
    jseq(80'h600df, {62'h0, 4'hf, ir, 10'h0}, 20);
  endtask : jir
  task automatic boot;
    SRST <= 1'b1;
    // tck idle low, so the pin filter sees no stray edge after reset
    JTAG_TCK <= 1'b0;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : boot
  task automatic print_verdict;
    $display("counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // ==========
  // tests
  initial begin
    boot();
    LINK_REQ <= 1'b1;
    pgm(16'h0200, 32'h1);
    chk(32'(n_pgm), 32'h0);
    while (CORE_RUN !== 1'b1) @(posedge CLK);
    @(posedge CLK);
    chk(32'(n_we), 32'd2048);
    chk(row5, 32'hc3a5_0005);
    rdc(REG_SEC, 32'ha955_81a2);
    chk({27'h0, BOOT_FROM_OTP, BOOT_FROM_FLASH, OTP_REDUND_EN, LINK_DENY, LINK_GRANT}, 32'h16);
    LINK_REQ <= 1'b0;
    rdc(REG_STAT, 32'hd);
    ahb(1'b1, REG_STAT, 32'he);
    rdc(REG_STAT, 32'h1);
    ahb(1'b1, REG_SEC, 32'h0);
    rdc(REG_SEC, 32'ha955_81a2);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    $display("test boot and registers done");
    pgm(16'h0200, 32'h1234_5678);
    chk(32'(n_pgm), 32'h1);
    chk(OTP_PGM_DATA, 32'h1234_5678);
    chk({OTP_PGM_ADDR, OTP_PGM_CTRL}, 32'h0200_0001);
    pgm(16'h0010, 32'h1);
    chk(32'(n_pgm), 32'h1);
    rdc(REG_STAT, 32'h7);
    // locks jtag, otp access, sector 1 and everything for the next power up
    pgm(16'h0800, 32'h0000_3201);
    chk(32'(n_pgm), 32'h2);
    rdc(REG_SEC, 32'ha955_81a2);
    $display("test programming done");
    jseq(80'h0300_0000_0000_0000_005f, 80'h0, 75);
    chk({tdo[36:21], tdo[68:53]}, 32'h0003_0002);
    chk({30'h0, tdo[41], tdo[9]}, 32'h3);
    jir(IR_ACCESS);
    chk({31'h0, JTAG_TILE_SEL}, 32'h1);
    jseq(80'h1f, 80'h0, 5);
    chk({31'h0, JTAG_TILE_SEL}, 32'h0);
    jir(IR_OTP);
    chk({31'h0, JTAG_OTP_SEL}, 32'h1);
    // boundary tap takes access, chip tap goes to bypass
    jseq(80'h600df, {62'h0, 4'h3, 4'hf, 10'h0}, 20);
    chk({30'h0, BSCAN_EXTEST, JTAG_OTP_SEL}, 32'h2);
    $display("test jtag open done");
    boot();
    while (CORE_RUN !== 1'b1) @(posedge CLK);
    rdc(REG_SEC, 32'ha955_b3a3);
    pgm(16'h0200, 32'h1);
    pgm(16'h0800, 32'h1);
    chk(32'(n_pgm), 32'h2);
    jir(IR_ACCESS);
    chk({31'h0, JTAG_TILE_SEL}, 32'h0);
    jir(IR_OTP);
    chk({31'h0, JTAG_OTP_SEL}, 32'h0);
    jir(IR_USERCODE);
    // dr scan: capture, 35 shifts, update
    jseq(80'h60_0000_0001, 80'h0, 40);
    chk(tdo[34:3], 32'ha940_0001);
    $display("test locked part done");
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    failures++;
    print_verdict();
  end
endmodule : tb_otp_security_jtag_id
